/* File: hw/abx_exec_unit.sv */
// Execute unit: arithmetic, logic, compares, skips, branches, calls
//
// Contract
// RL1: Add and add-with-carry update five flags, one cycle
// RL2: Word add/subtract immediate on pair, two cycles
// RL3: Subtract register or immediate, five flags, one cycle
// RL4: Subtract with borrow, same flags, one cycle
// RL5: And, or, xor: nil, msb, wrap only
// RL6: Set bits by or, clear bits by inverted mask
// RL7: Probe ands register with itself, flags only
// RL8: Pointer jump loads pc from pair three, two cycles
// RL9: Calls push return address, take three cycles
// RL10: Equal skip advances pc two or three
// RL11: Compares set five flags, store nothing
// RL12: Register bit skips on clear or set
// RL13: I/O bit skips on clear or set
// RL14: Flag branches test any flags_byte bit
// RL15: Carry branches test unsigned_borrow_out
// RL16: Same-or-higher and lower alias carry branches
// RL17: Signed branches test msb xor wrap
// RL18: Half-carry branches test low_nibble_carry
// RL19: User-bit branches test user_bool_flag
// RL20: Wrap and sign branches test their flags
// RL21: Interrupt and zero branches test their flags
// RL22: Thirty-two byte working registers feed the adder
// RL23: Skip steps over one- or two-word instruction
// RL24: False condition one cycle, true two, three for a skip over a two-word instruction
// RL25: Unlisted flags keep their previous values
//
// The implementer's own choices: the address map and strobed register access.
module abx_exec_unit
  import abx_pkg::*;
#(
  parameter int unsigned PC_W = PC_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Instruction issue
  input wire logic issue,
  input wire abx_op_t op,
  input wire logic [RIX_W-1:0] dst_ix,
  input wire logic [RIX_W-1:0] src_ix,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic signed [OFFS_W-1:0] jump_offset,
  input wire logic io_bit,
  input wire logic next_two_word,
  output logic busy,
  // Program flow and status
  output logic [PC_W-1:0] pc,
  output logic push_valid,
  output logic [PC_W-1:0] push_addr,
  output logic [7:0] flags_byte,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    abx_phase_t ph;
    logic [1:0] left;
    logic [PC_W-1:0] pc;
    logic [7:0] fl;
    logic hi_pend;
    logic [RIX_W-1:0] hi_ix;
    logic [7:0] hi_val;
    logic push;
    logic [PC_W-1:0] ret;
    logic rsel;
    logic [7:0] rmisc;
  } abx_exec_st_t;

  localparam abx_exec_st_t ST_RST = '0;
  localparam logic [PC_W-1:0] PC_ONE = PC_W'(PC_STEP);
  localparam logic [PC_W-1:0] PC_SK1 = PC_W'(SKIP_ONE);
  localparam logic [PC_W-1:0] PC_SK2 = PC_W'(SKIP_TWO);

  abx_exec_st_t s_q;
  abx_exec_st_t s_d;

  // ****************************************
  // Datapath signals
  // ****************************************
  logic rf_we;
  logic [RIX_W-1:0] rf_wa;
  logic [7:0] rf_wd;
  logic [RIX_W-1:0] rf_ra;
  logic [RIX_W-1:0] rf_rb;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rf_brd;
  logic is_ptr;
  logic is_word;
  logic use_imm;
  logic [7:0] opb;
  logic [15:0] word_in;
  logic [15:0] word_out;
  logic [7:0] lres;
  logic is_br;
  logic is_skip;
  logic cond;
  logic accept;
  logic [1:0] cyc;
  logic [7:0] f;
  logic [PC_W-1:0] rel_pc;

  abx_alu_if alu_bus ();

  abx_adder u_adder (
    .p (alu_bus)
  );

  // RL22
  abx_regfile #(
    .DEPTH (NREG),
    .AW (RIX_W)
  ) u_regs (
    .mclk (mclk),
    .rst_n (rst_n),
    .we (rf_we),
    .wa (rf_wa),
    .wd (rf_wd),
    .ra (rf_ra),
    .rb (rf_rb),
    .rd_a (rd_a),
    .rd_b (rd_b),
    .re (reg_rd),
    .raddr (reg_addr[RIX_W-1:0]),
    .rdata (rf_brd)
  );

  // ****************************************
  // Operand selection
  // ****************************************
  assign is_ptr = (op == ptr_goto_op) || (op == ptr_sub_entry_op);
  assign is_word = (op == word_plus_imm_op) || (op == word_minus_imm_op);
  assign use_imm = op inside {minus_imm_op, borrow_minus_imm_op,
                              conj_imm_op, disj_imm_op, bits_on_op,
                              bits_off_op, cmp_imm_op};
  assign rf_ra = is_ptr ? PTR_LO : dst_ix;
  assign rf_rb = is_ptr ? PTR_HI
               : is_word ? dst_ix + RIX_ONE : src_ix;
  assign opb = use_imm ? imm : rd_b;

  assign alu_bus.a = rd_a;
  assign alu_bus.b = opb;
  assign alu_bus.sub = !(op inside {sum_op, sum_carry_op}); // RL1 RL3
  assign alu_bus.cin = s_q.fl[FL_CARRY] // RL4
                       && (op inside {sum_carry_op, borrow_minus_op,
                                      borrow_minus_imm_op, cmp_carry_op});

  // Register pair is high:low; the immediate is zero extended
  assign word_in = {rd_b, rd_a};
  assign word_out = (op == word_minus_imm_op) // RL2
                  ? word_in - {BYTE_ZERO, imm}
                  : word_in + {BYTE_ZERO, imm};

  assign rel_pc = s_q.pc + PC_W'(jump_offset) + PC_ONE;

  // ****************************************
  // Logic results and conditions
  // ****************************************
  always_comb begin
    lres = rd_a & opb; // RL5
    is_br = 1'b1;
    is_skip = 1'b0;
    cond = 1'b0;
    unique case (op)
      disj_op, disj_imm_op, bits_on_op: lres = rd_a | opb; // RL5 RL6
      exclusive_disj_op: lres = rd_a ^ opb; // RL5
      bits_off_op: lres = rd_a & (BYTE_ONES - imm); // RL6
      zero_sign_probe_op: lres = rd_a & rd_a; // RL7
      default: lres = rd_a & opb;
    endcase
    unique case (op)
      flag_set_branch_op: cond = s_q.fl[bit_sel]; // RL14
      flag_clear_branch_op: cond = !s_q.fl[bit_sel]; // RL14
      zero_branch_op: cond = s_q.fl[FL_NIL]; // RL21
      nonzero_branch_op: cond = !s_q.fl[FL_NIL]; // RL21
      carry_set_branch_op, lower_branch_op:
        cond = s_q.fl[FL_CARRY]; // RL15 RL16
      carry_clear_branch_op, same_higher_branch_op:
        cond = !s_q.fl[FL_CARRY]; // RL15 RL16
      minus_branch_op: cond = s_q.fl[FL_MSB]; // RL20
      plus_branch_op: cond = !s_q.fl[FL_MSB]; // RL20
      sgn_ge_branch_op:
        cond = !(s_q.fl[FL_MSB] ^ s_q.fl[FL_WRAP]); // RL17
      sgn_lt_branch_op:
        cond = s_q.fl[FL_MSB] ^ s_q.fl[FL_WRAP]; // RL17
      half_set_branch_op: cond = s_q.fl[FL_HALF]; // RL18
      half_clear_branch_op: cond = !s_q.fl[FL_HALF]; // RL18
      user_set_branch_op: cond = s_q.fl[FL_USER]; // RL19
      user_clear_branch_op: cond = !s_q.fl[FL_USER]; // RL19
      wrap_set_branch_op: cond = s_q.fl[FL_WRAP]; // RL20
      wrap_clear_branch_op: cond = !s_q.fl[FL_WRAP]; // RL20
      int_on_branch_op: cond = s_q.fl[FL_GIE]; // RL21
      int_off_branch_op: cond = !s_q.fl[FL_GIE]; // RL21
      default: begin
        is_br = 1'b0;
        is_skip = 1'b1;
        unique case (op)
          equal_skip_op: cond = (rd_a == rd_b); // RL10
          reg_bit_clear_skip_op: cond = !rd_b[bit_sel]; // RL12
          reg_bit_set_skip_op: cond = rd_b[bit_sel]; // RL12
          io_bit_clear_skip_op: cond = !io_bit; // RL13
          io_bit_set_skip_op: cond = io_bit; // RL13
          default: is_skip = 1'b0;
        endcase
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    accept = issue && (s_q.ph == st_idle);
    cyc = CYC_ONE;
    f = s_q.fl; // RL25
    rf_we = 1'b0;
    rf_wa = dst_ix;
    rf_wd = alu_bus.r;

    if (accept) begin
      s_d.pc = s_q.pc + PC_ONE;
      unique case (op)
        sum_op, sum_carry_op, minus_reg_op, minus_imm_op,
        borrow_minus_op, borrow_minus_imm_op,
        cmp_reg_op, cmp_carry_op, cmp_imm_op: begin
          f[FL_CARRY] = alu_bus.c; // RL1 RL3 RL4 RL11
          f[FL_HALF] = alu_bus.h; // RL1 RL3 RL4 RL11
          f[FL_WRAP] = alu_bus.v; // RL1 RL3 RL4 RL11
          f[FL_MSB] = alu_bus.r[BYTE_MSB];
          f[FL_NIL] = (alu_bus.r == BYTE_ZERO);
          // RL11
          rf_we = !(op inside {cmp_reg_op, cmp_carry_op, cmp_imm_op});
        end
        conj_op, conj_imm_op, disj_op, disj_imm_op,
        exclusive_disj_op, bits_on_op, bits_off_op,
        zero_sign_probe_op: begin
          f[FL_NIL] = (lres == BYTE_ZERO); // RL5 RL6 RL7
          f[FL_MSB] = lres[BYTE_MSB]; // RL5 RL6 RL7
          f[FL_WRAP] = 1'b0; // RL5
          rf_wd = lres;
          rf_we = (op != zero_sign_probe_op); // RL7
        end
        word_plus_imm_op, word_minus_imm_op: begin
          f[FL_NIL] = (word_out == 16'h0000); // RL2
          f[FL_MSB] = word_out[WORD_MSB];
          if (op == word_plus_imm_op) begin
            f[FL_WRAP] = !word_in[WORD_MSB] && word_out[WORD_MSB];
            f[FL_CARRY] = word_in[WORD_MSB] && !word_out[WORD_MSB];
          end else begin
            f[FL_WRAP] = word_in[WORD_MSB] && !word_out[WORD_MSB];
            f[FL_CARRY] = !word_in[WORD_MSB] && word_out[WORD_MSB];
          end
          f[FL_ORDER] = f[FL_MSB] ^ f[FL_WRAP]; // RL2
          // Low byte now, high byte in the second cycle
          rf_we = 1'b1;
          rf_wd = word_out[7:0];
          s_d.hi_pend = 1'b1;
          s_d.hi_ix = rf_rb;
          s_d.hi_val = word_out[15:8];
          cyc = CYC_TWO; // RL2
        end
        rel_goto_op: begin
          s_d.pc = rel_pc;
          cyc = CYC_TWO;
        end
        ptr_goto_op: begin
          s_d.pc = PC_W'(word_in); // RL8
          cyc = CYC_TWO; // RL8
        end
        ptr_sub_entry_op, rel_sub_entry_op: begin
          s_d.pc = is_ptr ? PC_W'(word_in) : rel_pc; // RL9
          s_d.push = 1'b1; // RL9
          s_d.ret = s_q.pc + PC_ONE;
          cyc = CYC_THREE; // RL9
        end
        default: begin
          if (is_br && cond) begin
            s_d.pc = rel_pc; // RL14
            cyc = CYC_TWO; // RL24
          end else if (is_skip && cond) begin
            s_d.pc = s_q.pc + (next_two_word ? PC_SK2 : PC_SK1); // RL23
            cyc = next_two_word ? CYC_THREE : CYC_TWO; // RL24
          end
        end
      endcase
      s_d.fl = f;
      s_d.left = cyc - CYC_ONE;
      if (cyc != CYC_ONE) begin
        s_d.ph = st_busy;
      end
    end

    if (s_q.ph == st_busy) begin
      s_d.left = s_q.left - CYC_ONE;
      if (s_q.left == CYC_ONE) begin
        s_d.ph = st_idle;
      end
      if (s_q.hi_pend) begin
        rf_we = 1'b1;
        rf_wa = s_q.hi_ix;
        rf_wd = s_q.hi_val;
        s_d.hi_pend = 1'b0;
      end
    end

    // Software writes lose to the instruction in the same cycle
    if (reg_wr && !rf_we && (reg_addr < A_FLAGS)) begin
      rf_we = 1'b1;
      rf_wa = reg_addr[RIX_W-1:0];
      rf_wd = reg_wdata;
    end
    if (reg_wr && !accept && (s_q.ph == st_idle)) begin
      unique case (reg_addr)
        A_FLAGS: s_d.fl = reg_wdata;
        A_PC_LO: s_d.pc[7:0] = reg_wdata;
        A_PC_HI: s_d.pc[PC_W-1:PCHI_LSB] = reg_wdata[PC_W-1-PCHI_LSB:0];
        default: s_d.fl = s_q.fl;
      endcase
    end

    // Register port read, answered in the next cycle
    s_d.rsel = reg_rd && (reg_addr < A_FLAGS);
    s_d.rmisc = BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        A_FLAGS: s_d.rmisc = s_q.fl;
        A_PC_LO: s_d.rmisc = s_q.pc[7:0];
        A_PC_HI: s_d.rmisc = 8'(s_q.pc >> PCHI_LSB);
        default: s_d.rmisc = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy = (s_q.ph == st_busy);
  assign pc = s_q.pc;
  assign flags_byte = s_q.fl;
  assign push_valid = s_q.push;
  assign push_addr = s_q.ret;
  assign reg_rdata = s_q.rsel ? rf_brd : s_q.rmisc;

endmodule

/* File: inc/abx_pkg.sv */
// Shared constants and types of the execute unit
package abx_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned PC_BITS = 10;
  localparam int unsigned NREG = 32;
  localparam int unsigned RIX_W = 5;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned OFFS_W = 12;
  localparam int unsigned BYTE_MSB = 7;
  localparam int unsigned BYTE_CY = 8;
  localparam int unsigned NIB_CY = 4;
  localparam int unsigned WORD_MSB = 15;
  localparam int unsigned PCHI_LSB = 8;

  // ****************************************
  // Register port map
  // ****************************************
  localparam logic [5:0] A_FLAGS = 6'h20;
  localparam logic [5:0] A_PC_LO = 6'h21;
  localparam logic [5:0] A_PC_HI = 6'h22;

  // ****************************************
  // flags_byte bit positions and values
  // ****************************************
  localparam int unsigned FL_CARRY = 0;
  localparam int unsigned FL_NIL = 1;
  localparam int unsigned FL_MSB = 2;
  localparam int unsigned FL_WRAP = 3;
  localparam int unsigned FL_ORDER = 4;
  localparam int unsigned FL_HALF = 5;
  localparam int unsigned FL_USER = 6;
  localparam int unsigned FL_GIE = 7;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [4:0] PTR_LO = 5'h1e;
  localparam logic [4:0] PTR_HI = 5'h1f;
  localparam logic [4:0] RIX_ONE = 5'h01;

  // ****************************************
  // Cycle counts and program counter steps
  // ****************************************
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int unsigned PC_STEP = 1;
  localparam int unsigned SKIP_ONE = 2;
  localparam int unsigned SKIP_TWO = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {st_idle, st_busy} abx_phase_t;

  typedef enum logic [5:0] {
    nop_op, sum_op, sum_carry_op, word_plus_imm_op, word_minus_imm_op,
    minus_reg_op, minus_imm_op, borrow_minus_op, borrow_minus_imm_op,
    conj_op, conj_imm_op, disj_op, disj_imm_op, exclusive_disj_op,
    bits_on_op, bits_off_op, zero_sign_probe_op,
    rel_goto_op, ptr_goto_op, rel_sub_entry_op, ptr_sub_entry_op,
    equal_skip_op, cmp_reg_op, cmp_carry_op, cmp_imm_op,
    reg_bit_clear_skip_op, reg_bit_set_skip_op,
    io_bit_clear_skip_op, io_bit_set_skip_op,
    flag_set_branch_op, flag_clear_branch_op,
    zero_branch_op, nonzero_branch_op,
    carry_set_branch_op, carry_clear_branch_op,
    same_higher_branch_op, lower_branch_op,
    minus_branch_op, plus_branch_op,
    sgn_ge_branch_op, sgn_lt_branch_op,
    half_set_branch_op, half_clear_branch_op,
    user_set_branch_op, user_clear_branch_op,
    wrap_set_branch_op, wrap_clear_branch_op,
    int_on_branch_op, int_off_branch_op
  } abx_op_t;

endpackage

/* File: inc/abx_alu_if.sv */
// Connection between the execute unit and its byte adder
interface abx_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic sub;
  logic [7:0] r;
  logic c;
  logic h;
  logic v;
  modport user (output a, b, cin, sub, input r, c, h, v);
  modport unit (input a, b, cin, sub, output r, c, h, v);
endinterface

/* File: hw/abx_adder.sv */
// Byte adder and subtractor with carry, half carry and overflow
module abx_adder
  import abx_pkg::*;
(
  // Operands and results
  abx_alu_if.unit p
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    if (p.sub) begin
      full = {1'b0, p.a} - {1'b0, p.b} - {8'h00, p.cin};
      low = {1'b0, p.a[3:0]} - {1'b0, p.b[3:0]} - {4'h0, p.cin};
    end else begin
      full = {1'b0, p.a} + {1'b0, p.b} + {8'h00, p.cin};
      low = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]} + {4'h0, p.cin};
    end
  end

  // In subtract mode the carry outputs read as borrows
  assign p.r = full[7:0];
  assign p.c = full[BYTE_CY];
  assign p.h = low[NIB_CY];
  assign p.v = (p.sub ? (p.a[BYTE_MSB] != p.b[BYTE_MSB])
                      : (p.a[BYTE_MSB] == p.b[BYTE_MSB]))
               && (full[BYTE_MSB] != p.a[BYTE_MSB]);

endmodule

/* File: hw/abx_regfile.sv */
// Working register file: two operand ports and one registered port
module abx_regfile
  import abx_pkg::*;
#(
  parameter int unsigned DEPTH = NREG,
  parameter int unsigned AW = RIX_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [7:0] wd,
  // Operand read ports
  input wire logic [AW-1:0] ra,
  input wire logic [AW-1:0] rb,
  output logic [7:0] rd_a,
  output logic [7:0] rd_b,
  // Registered read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } abx_rf_st_t;

  abx_rf_st_t s_q;
  abx_rf_st_t s_d;

  // Registered read sees the value before a same-cycle write
  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.mem[wa] = wd;
    end
    if (re) begin
      s_d.rdata = s_q.mem[raddr];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_a = s_q.mem[ra];
  assign rd_b = s_q.mem[rb];
  assign rdata = s_q.rdata;

endmodule

/* File: sim/abx_exec_unit_assertions.sv */
// Port-level checker of the execute unit
module abx_exec_chk
  import abx_pkg::*;
#(
  parameter int unsigned PC_W = PC_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Issue side
  input wire logic issue,
  input wire abx_op_t op,
  input wire logic signed [OFFS_W-1:0] jump_offset,
  input wire logic io_bit,
  input wire logic next_two_word,
  input wire logic busy,
  // Program flow and status
  input wire logic [PC_W-1:0] pc,
  input wire logic push_valid,
  input wire logic [PC_W-1:0] push_addr,
  input wire logic [7:0] flags_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Helpers
  // ****************************************
  wire logic acc = issue && !busy;
  wire logic [PC_W-1:0] tgt = pc + PC_W'(jump_offset) + 1'h1;
  wire logic [PC_W-1:0] pc1 = pc + 1'h1;
  wire logic [PC_W-1:0] pc3 = pc + 2'h3;
  // ****************************************
  // Properties
  // ****************************************
  property p_call_push;
    acc && op == rel_sub_entry_op |=> push_valid &&
      push_addr == $past(pc1) && pc == $past(tgt);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call target or return address wrong");
  property p_push_len;
    push_valid |-> busy ##1 (busy && !push_valid) ##1 !busy;
  endproperty
  a_push_len: assert property (p_push_len)
    else $error("call did not take three cycles");
  property p_logic_flags;
    acc && op inside {conj_op, conj_imm_op, disj_op, disj_imm_op,
      exclusive_disj_op} |=> !flags_byte[FL_WRAP] &&
      $stable(flags_byte[FL_CARRY]) && $stable(flags_byte[FL_HALF]);
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic op touched carry, half or wrap");
  property p_branch_keep;
    acc && op inside {[flag_set_branch_op:int_off_branch_op]}
      |=> $stable(flags_byte);
  endproperty
  a_branch_keep: assert property (p_branch_keep)
    else $error("branch changed flags");
  property p_false_branch;
    acc && op == carry_set_branch_op && !flags_byte[FL_CARRY]
      |=> !busy && pc == $past(pc1);
  endproperty
  a_false_branch: assert property (p_false_branch)
    else $error("untaken branch not one cycle");
  property p_signed_lt;
    acc && op == sgn_lt_branch_op && (flags_byte[FL_MSB] ^
      flags_byte[FL_WRAP]) |=> busy && pc == $past(tgt) ##1 !busy;
  endproperty
  a_signed_lt: assert property (p_signed_lt)
    else $error("signed branch not taken");
  property p_skip_long;
    acc && op == io_bit_set_skip_op && io_bit && next_two_word
      |=> pc == $past(pc3) && busy ##1 busy ##1 !busy;
  endproperty
  a_skip_long: assert property (p_skip_long)
    else $error("skip over two words wrong");
  property p_word_len;
    acc && op inside {word_plus_imm_op, word_minus_imm_op}
      |=> busy ##1 !busy;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word op not two cycles");
  property p_ptr_len;
    acc && op == ptr_goto_op |=> busy && $stable(flags_byte) ##1 !busy;
  endproperty
  a_ptr_len: assert property (p_ptr_len)
    else $error("pointer jump length or flags wrong");
endmodule

bind abx_exec_unit abx_exec_chk #(.PC_W(PC_W)) chk_i (
  .mclk(mclk), .rst_n(rst_n), .issue(issue), .op(op),
  .jump_offset(jump_offset), .io_bit(io_bit),
  .next_two_word(next_two_word), .busy(busy), .pc(pc),
  .push_valid(push_valid), .push_addr(push_addr),
  .flags_byte(flags_byte)
);

/* File: sim/abx_testbench.sv */
// Self-checking bench of the execute unit
module testbench
  import abx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, issue, io_bit, next_two_word, busy, push_valid;
  logic reg_wr, reg_rd, pv, t, v;
  abx_op_t op;
  logic [4:0] dst_ix, src_ix;
  logic [7:0] imm, flags_byte, reg_wdata, reg_rdata;
  logic [2:0] bit_sel, b;
  logic signed [OFFS_W-1:0] jump_offset;
  logic [PC_BITS-1:0] pc, push_addr, epc, pa, ret;
  logic [5:0] reg_addr;
  logic [8:0] g;
  logic [7:0] fv [3] = '{8'h00, 8'hff, 8'h44};
  int idx [10] = '{0, 1, 0, 0, 2, 8, 5, 6, 3, 7};
  int bad_count, n_compared, p, st;

  abx_exec_unit abx_exec_unit_i (
    .mclk(mclk), .rst_n(rst_n), .issue(issue), .op(op),
    .dst_ix(dst_ix), .src_ix(src_ix), .imm(imm), .bit_sel(bit_sel),
    .jump_offset(jump_offset), .io_bit(io_bit),
    .next_two_word(next_two_word), .busy(busy), .pc(pc),
    .push_valid(push_valid), .push_addr(push_addr),
    .flags_byte(flags_byte), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(logic [5:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic ex(abx_op_t o, int cyc, logic [PC_BITS-1:0] npc,
      logic [4:0] d = 0, logic [4:0] s = 0, logic [7:0] k = 0,
      logic [2:0] bs = 0, logic [OFFS_W-1:0] j = 0, logic io = 0,
      logic nt = 0);
    int n;
    issue <= 1'h1;
    op <= o;
    dst_ix <= d;
    src_ix <= s;
    imm <= k;
    bit_sel <= bs;
    jump_offset <= j;
    io_bit <= io;
    next_two_word <= nt;
    @(posedge mclk);
    issue <= 1'h0;
    #1;
    pv = push_valid;
    pa = push_addr;
    n = 1;
    while (busy !== 1'h0 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n, cyc);
    chk(pc, npc);
    epc = npc;
    rd(A_PC_LO, epc[7:0]);
    rd(A_PC_HI, 8'(epc >> 8));
  endtask

  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {issue, io_bit, next_two_word, reg_wr, reg_rd} = 5'h00;
    {dst_ix, src_ix, imm, bit_sel, reg_wdata, reg_addr} = 35'h0;
    op = nop_op;
    jump_offset = 12'h000;
    epc = 10'h000;
    rst_n = 1'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    rd(A_FLAGS, 8'h00);
    wr(6'h3f, 8'haa);
    rd(6'h3f, 8'h00);
    wr(1, 8'h0f);
    wr(2, 8'h01);
    rd(1, 8'h0f);
    ex(sum_op, 1, epc + 1, 1, 2);
    rd(1, 8'h10);
    rd(A_FLAGS, 8'h20);
    wr(A_FLAGS, 8'hd1);
    wr(3, 8'h7f);
    ex(sum_carry_op, 1, epc + 1, 3, 4);
    rd(3, 8'h80);
    rd(A_FLAGS, 8'hfc);
    ex(minus_imm_op, 1, epc + 1, 3, 0, 8'h01);
    rd(3, 8'h7f);
    rd(A_FLAGS, 8'hf8);
    wr(A_FLAGS, 8'h01);
    ex(borrow_minus_op, 1, epc + 1, 5, 6);
    rd(5, 8'hff);
    rd(A_FLAGS, 8'h25);
    ex(conj_imm_op, 1, epc + 1, 5, 0, 8'h00);
    rd(5, 8'h00);
    rd(A_FLAGS, 8'h23);
    wr(7, 8'hff);
    ex(bits_off_op, 1, epc + 1, 7, 0, 8'h0f);
    rd(7, 8'hf0);
    ex(zero_sign_probe_op, 1, epc + 1, 7);
    rd(7, 8'hf0);
    rd(A_FLAGS, 8'h25);
    wr(24, 8'hff);
    wr(25, 8'h7f);
    ex(word_plus_imm_op, 2, epc + 1, 24, 0, 8'h01);
    rd(25, 8'h80);
    rd(A_FLAGS, 8'h2c);
    ex(word_minus_imm_op, 2, epc + 1, 24, 0, 8'h01);
    rd(24, 8'hff);
    rd(A_FLAGS, 8'h38);
    ex(cmp_reg_op, 1, epc + 1, 1, 2);
    rd(1, 8'h10);
    rd(A_FLAGS, 8'h30);
    ex(minus_reg_op, 1, epc + 1, 2, 1);
    rd(2, 8'hf1);
    rd(A_FLAGS, 8'h15);
    ex(cmp_carry_op, 1, epc + 1, 1, 1);
    rd(1, 8'h10);
    rd(A_FLAGS, 8'h35);
    ex(borrow_minus_imm_op, 1, epc + 1, 3, 0, 8'h7e);
    rd(3, 8'h00);
    rd(A_FLAGS, 8'h12);
    ex(cmp_imm_op, 1, epc + 1, 7, 0, 8'hf1);
    rd(A_FLAGS, 8'h35);
    ex(exclusive_disj_op, 1, epc + 1, 2, 1);
    rd(2, 8'he1);
    ex(disj_imm_op, 1, epc + 1, 3, 0, 8'h00);
    rd(A_FLAGS, 8'h33);
    ex(disj_op, 1, epc + 1, 3, 2);
    rd(3, 8'he1);
    ex(conj_op, 1, epc + 1, 3, 1);
    rd(3, 8'h00);
    ex(bits_on_op, 1, epc + 1, 3, 0, 8'h81);
    rd(3, 8'h81);
    rd(A_FLAGS, 8'h35);
    ex(nop_op, 1, epc + 1);
    ex(rel_goto_op, 2, epc + 17, 0, 0, 0, 0, 12'h010);
    rd(A_FLAGS, 8'h35);
    $display("arithmetic test done");
    ex(equal_skip_op, 3, epc + 3, 1, 1, 0, 0, 0, 0, 1);
    ex(equal_skip_op, 1, epc + 1, 1, 2);
    for (int i = 0; i < 16; i++) begin
      v = i[1];
      st = (v ^ !i[2]) ? (i[0] ? 3 : 2) : 1;
      ex(abx_op_t'(reg_bit_clear_skip_op + i / 4), st, epc + st, 0, 7,
        0, v ? 3'h4 : 3'h0, 0, v, i[0]);
    end
    $display("skip test done");
    // Three flag patterns; 0x44 splits msb xor wrap from bit 4
    for (int m = 0; m < 3; m++) begin
      wr(A_FLAGS, fv[m]);
      for (int i = 0; i < 20; i++) begin
        g = {fv[m][FL_MSB] ^ fv[m][FL_WRAP], fv[m]};
        b = 3'(i + m);
        p = i / 2;
        t = g[p == 0 ? b : idx[p]] ^ i[0] ^ (p == 3 || p == 5);
        ex(abx_op_t'(flag_set_branch_op + i), t ? 2 : 1,
          t ? epc + 10'h3fe : epc + 1, 0, 0, 0, b, 12'hffd);
        rd(A_FLAGS, fv[m]);
        chk(flags_byte, fv[m]);
      end
    end
    $display("branch test done");
    ret = epc + 1;
    ex(rel_sub_entry_op, 3, epc + 6, 0, 0, 0, 0, 12'h005);
    chk(pv, 1'h1);
    chk(pa, ret);
    wr(30, 8'h12);
    wr(31, 8'h01);
    ex(ptr_goto_op, 2, 10'h112);
    wr(30, 8'h34);
    wr(31, 8'h02);
    ret = epc + 1;
    ex(ptr_sub_entry_op, 3, 10'h234);
    chk(pv, 1'h1);
    chk(pa, ret);
    $display("jump test done");
    end_sim();
  end

  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
